/* design/gpio_port_b.sv */
// Eight-bit port B with pull-ups, change detection and a Wishbone register slave.
`timescale 1ns/10ps
`include "gpio_port_b_map.svh"
// How it works
// - Eight pins, each with direction bit, output latch bit and readable level.
// - Direction bit one releases the pin driver; pin is an input.
// - Direction bit zero drives the pin from its output latch bit.
// - Output latch has its own address and reads back latched values.
// - Clearing bit 7 of second control register enables pull-ups on pins set as inputs.
// - A pin set as output never has its pull-up on.
// - Reset sets second control register to all ones, pull-ups off.
// - Every reset sets all direction bits, all pins inputs.
// - Change detection covers upper four pins, skipping those set as outputs.
// - Each watched upper pin compares against value captured at last port access.
// - Four mismatches ORed set change flag at bit 0 of main control.
// - An enabled pending change flag raises the wake request.
// - Port accesses refresh the reference, except register-to-register moves.
// - A lasting mismatch keeps setting the flag despite software clears.
// - Route bit moves capture/compare 2 onto pin 3 in external modes.
// - Low-voltage programming makes pin 5 the programming enable, pull-up off.
// - Pins 0-3 select Schmitt buffering as interrupt or capture inputs.
// - Serial programming uses Schmitt buffers on pins 5-7, clock and data.
// - Port reads return pin levels; port writes update the output latch.
module gpio_port_b #(
	parameter int PINS = `PB_W
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PB_WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [`PB_WB_DW-1:0] wb_dat_i,
	input wire logic wb_tga_i,
	output logic [`PB_WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Board pins.
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	output logic [PINS-1:0] pullupEn,
	output logic [PINS-1:0] schmittSel,
	// Peripheral hooks.
	input wire logic ccp2Out,
	output logic ccp2CaptureIn,
	output logic [`PB_NIB-1:0] extIrqLevel,
	output logic progEnable,
	output logic progClock,
	output logic progData,
	output logic wakeReq
);
	// ==========================================================
	// State
	gpio_port_b_pkg::state_t st;
	gpio_port_b_pkg::state_t next_st;
	logic take;
	logic wrFire;
	logic [`PB_NIB-1:0] watched;
	logic [`PB_NIB-1:0] mismatchVec;
	logic changeSeen;
	logic routeActive;
	logic low_voltage_prog_cfg;

	function automatic logic hit(input logic [`PB_WB_AW-1:0] a, input logic [`PB_WB_AW-1:0] off);
		hit = (a == off);
	endfunction : hit

	assign take = wb_cyc_i && wb_stb_i && !st.ack;
	assign wrFire = wb_cyc_i && wb_stb_i && wb_we_i && st.ack && wb_sel_i[0];
	assign low_voltage_prog_cfg = st.cfg[`PB_CFG_LVP];
	assign routeActive = st.cfg[`PB_CFG_ROUTE] && st.cfg[`PB_CFG_EXTMODE];
	assign watched = st.dir[PINS-1:`PB_NIB]
		& ~({3'h0, low_voltage_prog_cfg} << (`PB_PIN_PGM - `PB_NIB));
	assign mismatchVec = (st.sync2[PINS-1:`PB_NIB] ^ st.refVal) & watched;
	assign changeSeen = |mismatchVec;

	// ==========================================================
	// Next state
	always_comb
	begin
		next_st = st;
		next_st.sync1 = pinIn;
		next_st.sync2 = st.sync1;
		next_st.ack = take;
		if (take)
		begin
			next_st.rdData = '0;
			if (hit(wb_adr_i, `PB_OFF_PORT))
			begin
				next_st.rdData[`PB_W-1:0] = st.sync2 & ~({7'h00, low_voltage_prog_cfg} << `PB_PIN_PGM);
			end
			else if (hit(wb_adr_i, `PB_OFF_LATCH))
			begin
				next_st.rdData[`PB_W-1:0] = st.latch;
			end
			else if (hit(wb_adr_i, `PB_OFF_DIR))
			begin
				next_st.rdData[`PB_W-1:0] = st.dir;
			end
			else if (hit(wb_adr_i, `PB_OFF_CTRL1))
			begin
				next_st.rdData[`PB_W-1:0] = st.ctrl1;
			end
			else if (hit(wb_adr_i, `PB_OFF_CTRL2))
			begin
				next_st.rdData[`PB_W-1:0] = st.ctrl2;
			end
			else if (hit(wb_adr_i, `PB_OFF_CTRL3))
			begin
				next_st.rdData[`PB_W-1:0] = st.ctrl3;
			end
			else if (hit(wb_adr_i, `PB_OFF_CFG))
			begin
				next_st.rdData[`PB_CFG_W-1:0] = st.cfg;
			end
			if (hit(wb_adr_i, `PB_OFF_PORT) && !wb_tga_i)
			begin
				next_st.refVal = st.sync2[PINS-1:`PB_NIB];
			end
		end
		if (wrFire)
		begin
			if (hit(wb_adr_i, `PB_OFF_PORT) || hit(wb_adr_i, `PB_OFF_LATCH))
			begin
				next_st.latch = wb_dat_i[`PB_W-1:0];
			end
			else if (hit(wb_adr_i, `PB_OFF_DIR))
			begin
				next_st.dir = wb_dat_i[`PB_W-1:0];
			end
			else if (hit(wb_adr_i, `PB_OFF_CTRL1))
			begin
				next_st.ctrl1 = wb_dat_i[`PB_W-1:0];
			end
			else if (hit(wb_adr_i, `PB_OFF_CTRL2))
			begin
				next_st.ctrl2 = wb_dat_i[`PB_W-1:0];
			end
			else if (hit(wb_adr_i, `PB_OFF_CTRL3))
			begin
				next_st.ctrl3 = wb_dat_i[`PB_W-1:0];
			end
			else if (hit(wb_adr_i, `PB_OFF_CFG))
			begin
				next_st.cfg = wb_dat_i[`PB_CFG_W-1:0];
			end
		end
		if (changeSeen)
		begin
			next_st.ctrl1[`PB_BIT_FLAG] = 1'b1;
		end
		next_st.pinOe = ~st.dir;
		next_st.pinOut = st.latch;
		if (routeActive)
		begin
			next_st.pinOut[`PB_PIN_CCP] = ccp2Out;
		end
		next_st.pullupEn = st.ctrl2[`PB_BIT_PULLUP_N] ? '0 : st.dir;
		if (low_voltage_prog_cfg)
		begin
			next_st.pinOe[`PB_PIN_PGM] = 1'b0;
			next_st.pullupEn[`PB_PIN_PGM] = 1'b0;
		end
		next_st.progEnable = low_voltage_prog_cfg && st.sync2[`PB_PIN_PGM];
		// Schmitt for interrupt or capture use
		next_st.schmittSel = '0;
		next_st.schmittSel[0] = st.ctrl1[`PB_BIT_EXT_IRQ_IN_0_EN];
		next_st.schmittSel[1] = st.ctrl3[`PB_BIT_EXT_IRQ_IN_1_EN];
		next_st.schmittSel[2] = st.ctrl3[`PB_BIT_EXT_IRQ_IN_2_EN];
		next_st.schmittSel[3] = st.ctrl3[`PB_BIT_EXT_IRQ_IN_3_EN] || routeActive;
		if (st.cfg[`PB_CFG_SERPROG])
		begin
			next_st.schmittSel[`PB_PIN_PGM] = 1'b1;
			next_st.schmittSel[`PB_PIN_PGC] = 1'b1;
			next_st.schmittSel[`PB_PIN_PGD] = 1'b1;
		end
		next_st.progClock = st.cfg[`PB_CFG_SERPROG] && st.sync2[`PB_PIN_PGC];
		next_st.progData = st.cfg[`PB_CFG_SERPROG] && st.sync2[`PB_PIN_PGD];
		next_st.captureIn = routeActive && st.sync2[`PB_PIN_CCP];
		next_st.extIrqLevel = st.sync2[`PB_NIB-1:0];
		next_st.wakeReq = st.ctrl1[`PB_BIT_FLAG] && st.ctrl1[`PB_BIT_CHG_EN];
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.dir <= `PB_RST_DIR;
			st.ctrl1 <= `PB_RST_CTRL1;
			st.ctrl2 <= `PB_RST_CTRL2;
			st.ctrl3 <= `PB_RST_CTRL3;
			st.latch <= `PB_RST_ZERO8;
			st.cfg <= `PB_RST_CFG;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	assign wb_dat_o = st.rdData;
	assign wb_ack_o = st.ack;
	assign pinOut = st.pinOut;
	assign pinOe = st.pinOe;
	assign pullupEn = st.pullupEn;
	assign schmittSel = st.schmittSel;
	assign ccp2CaptureIn = st.captureIn;
	assign extIrqLevel = st.extIrqLevel;
	assign progEnable = st.progEnable;
	assign progClock = st.progClock;
	assign progData = st.progData;
	assign wakeReq = st.wakeReq;

	// ==========================================================
	// Checks
	property p_dirReset;
		@(posedge clk_sys) disable iff (sys_rst)
		$past(sys_rst) |-> (st.dir == `PB_RST_DIR) && (pinOe == '0);
	endproperty
	a_dirReset: assert property (p_dirReset) else $error("direction not all inputs after reset");

	property p_ctrl2Reset;
		@(posedge clk_sys) disable iff (sys_rst)
		$past(sys_rst) |-> (st.ctrl2 == `PB_RST_CTRL2) ##1 (pullupEn == '0);
	endproperty
	a_ctrl2Reset: assert property (p_ctrl2Reset) else $error("pull-ups not off after reset");

	property p_inputReleased;
		@(posedge clk_sys) disable iff (sys_rst)
		(st.pinOe & $past(st.dir)) == '0;
	endproperty
	a_inputReleased: assert property (p_inputReleased) else $error("input pin driven");

	property p_outputDriven;
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(low_voltage_prog_cfg) |-> ((~st.pinOe ^ $past(st.dir)) == '0)
			&& (((st.pinOut ^ $past(st.latch)) & 8'hF7) == '0);
	endproperty
	a_outputDriven: assert property (p_outputDriven) else $error("output not from latch");

	property p_pullupOff;
		@(posedge clk_sys) disable iff (sys_rst)
		((st.pullupEn & ~$past(st.dir)) == '0)
			&& (!$past(st.ctrl2[`PB_BIT_PULLUP_N]) || (st.pullupEn == '0));
	endproperty
	a_pullupOff: assert property (p_pullupOff) else $error("pull-up on illegally");

	property p_latchRead;
		@(posedge clk_sys) disable iff (sys_rst)
		take && !wb_we_i && (wb_adr_i == `PB_OFF_LATCH)
			|=> st.ack && (st.rdData[`PB_W-1:0] == $past(st.latch));
	endproperty
	a_latchRead: assert property (p_latchRead) else $error("latch readback wrong");

	property p_flagSet;
		@(posedge clk_sys) disable iff (sys_rst)
		changeSeen |=> st.ctrl1[`PB_BIT_FLAG] ##1 wakeReq == $past(st.ctrl1[`PB_BIT_CHG_EN]);
	endproperty
	a_flagSet: assert property (p_flagSet) else $error("change flag or wake missing");

	property p_refRefresh;
		@(posedge clk_sys) disable iff (sys_rst)
		take && (wb_adr_i == `PB_OFF_PORT)
			|=> $past(wb_tga_i) ? $stable(st.refVal)
				: (st.refVal == $past(st.sync2[PINS-1:`PB_NIB]));
	endproperty
	a_refRefresh: assert property (p_refRefresh) else $error("reference not refreshed");

	property p_lvpPin;
		@(posedge clk_sys) disable iff (sys_rst)
		$past(low_voltage_prog_cfg) |-> !st.pinOe[`PB_PIN_PGM] && !st.pullupEn[`PB_PIN_PGM]
			&& (progEnable == $past(st.sync2[`PB_PIN_PGM]));
	endproperty
	a_lvpPin: assert property (p_lvpPin) else $error("pin 5 not in programming use");

	property p_ackPulse;
		@(posedge clk_sys) disable iff (sys_rst)
		st.ack |=> !st.ack;
	endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack held two cycles");

	property p_wakeFollows;
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) |-> wakeReq == ($past(st.ctrl1[`PB_BIT_FLAG])
			&& $past(st.ctrl1[`PB_BIT_CHG_EN]));
	endproperty
	a_wakeFollows: assert property (p_wakeFollows) else $error("wake request wrong");

	property p_flagSticky;
		@(posedge clk_sys) disable iff (sys_rst)
		st.ctrl1[`PB_BIT_FLAG] && !(wrFire && (wb_adr_i == `PB_OFF_CTRL1))
			|=> st.ctrl1[`PB_BIT_FLAG];
	endproperty
	a_flagSticky: assert property (p_flagSticky) else $error("change flag lost");

	property p_refHold;
		@(posedge clk_sys) disable iff (sys_rst)
		!(take && (wb_adr_i == `PB_OFF_PORT)) |=> $stable(st.refVal);
	endproperty
	a_refHold: assert property (p_refHold) else $error("reference moved");

	property p_portWrite;
		@(posedge clk_sys) disable iff (sys_rst)
		wrFire && (wb_adr_i == `PB_OFF_PORT) |=> st.latch == $past(wb_dat_i[`PB_W-1:0]);
	endproperty
	a_portWrite: assert property (p_portWrite) else $error("port write missed latch");

	property p_routeOut;
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) && $past(routeActive) |-> pinOut[`PB_PIN_CCP] == $past(ccp2Out);
	endproperty
	a_routeOut: assert property (p_routeOut) else $error("pin 3 not from capture");

	property p_serialProg;
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) && $past(st.cfg[`PB_CFG_SERPROG]) |-> (schmittSel[7:5] == 3'h7)
			&& (progClock == $past(st.sync2[`PB_PIN_PGC]));
	endproperty
	a_serialProg: assert property (p_serialProg) else $error("serial pins wrong");
endmodule : gpio_port_b

/* design/gpio_port_b_map.svh */
// Register map, field positions and reset values of the port B block.
`ifndef GPIO_PORT_B_MAP_SVH
`define GPIO_PORT_B_MAP_SVH
`define PB_W 8
`define PB_NIB 4
`define PB_WB_AW 8
`define PB_WB_DW 32
`define PB_OFF_PORT 8'h00
`define PB_OFF_LATCH 8'h04
`define PB_OFF_DIR 8'h08
`define PB_OFF_CTRL1 8'h0C
`define PB_OFF_CTRL2 8'h10
`define PB_OFF_CTRL3 8'h14
`define PB_OFF_CFG 8'h18
`define PB_RST_DIR 8'hFF
`define PB_RST_CTRL1 8'h00
`define PB_RST_CTRL2 8'hFF
`define PB_RST_CTRL3 8'hC0
`define PB_RST_ZERO8 8'h00
`define PB_RST_CFG 4'h0
`define PB_CFG_W 4
`define PB_BIT_FLAG 0
`define PB_BIT_CHG_EN 3
`define PB_BIT_EXT_IRQ_IN_0_EN 4
`define PB_BIT_PULLUP_N 7
`define PB_BIT_EXT_IRQ_IN_1_EN 3
`define PB_BIT_EXT_IRQ_IN_2_EN 4
`define PB_BIT_EXT_IRQ_IN_3_EN 5
`define PB_CFG_ROUTE 0
`define PB_CFG_LVP 1
`define PB_CFG_EXTMODE 2
`define PB_CFG_SERPROG 3
`define PB_PIN_CCP 3
`define PB_PIN_PGM 5
`define PB_PIN_PGC 6
`define PB_PIN_PGD 7
`endif

/* design/gpio_port_b_pkg.sv */
// Types shared by the port B block.
`include "gpio_port_b_map.svh"
package gpio_port_b_pkg;
	typedef struct packed {
		logic [`PB_W-1:0] sync1;
		logic [`PB_W-1:0] sync2;
		logic [`PB_NIB-1:0] refVal;
		logic [`PB_W-1:0] dir;
		logic [`PB_W-1:0] latch;
		logic [`PB_W-1:0] ctrl1;
		logic [`PB_W-1:0] ctrl2;
		logic [`PB_W-1:0] ctrl3;
		logic [`PB_CFG_W-1:0] cfg;
		logic ack;
		logic [`PB_WB_DW-1:0] rdData;
		logic [`PB_W-1:0] pinOut;
		logic [`PB_W-1:0] pinOe;
		logic [`PB_W-1:0] pullupEn;
		logic [`PB_W-1:0] schmittSel;
		logic [`PB_NIB-1:0] extIrqLevel;
		logic captureIn;
		logic progEnable;
		logic progClock;
		logic progData;
		logic wakeReq;
	} state_t;
endpackage : gpio_port_b_pkg

/* dv/board_model.sv */
// Board model: external drivers, weak pull-ups and floating pins.
`timescale 1ns/10ps
module board_model (
	// Clock.
	input wire logic clk_sys,
	// Device pin side.
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] pullupEn,
	output logic [7:0] pinIn,
	// Bench side.
	input wire logic [7:0] extEn,
	input wire logic [7:0] extVal
);
	logic [7:0] floatVal = 8'h00;
	// A released pin without pull-up wanders every cycle.
	always @(posedge clk_sys)
		floatVal <= ~floatVal;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pullupEn[i] ? 1'b1 : floatVal[i];
	end
endmodule : board_model

/* dv/tb_top.sv */
// Self-checking bench for the port B block.
`timescale 1ns/10ps
`include "gpio_port_b_map.svh"
module tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic wbReq = 1'b0;
	logic wbWe = 1'b0;
	logic wbTga = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [31:0] wbDatI = 32'h0;
	logic [31:0] wbDat;
	logic wbAck;
	logic [7:0] pinIn, pinOut, pinOe, pullupEn, schmittSel, extEn, extVal;
	logic [3:0] extIrq;
	logic ccpIn, progEn, progClk, progDat, wakeReq;
	logic [7:0] q;
	int num_errors = 0;
	int checks_done = 0;
	logic ccpOut = 1'b1;
	// The board drives every pin until a scenario lets go of it.
	initial extEn = 8'hFF;
	initial extVal = 8'h00;
	always #2 clk_sys = ~clk_sys;
	gpio_port_b gpio_port_b_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wbReq),
		.wb_stb_i(wbReq), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
		.wb_dat_i(wbDatI), .wb_tga_i(wbTga), .wb_dat_o(wbDat), .wb_ack_o(wbAck),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
		.schmittSel(schmittSel), .ccp2Out(ccpOut), .ccp2CaptureIn(ccpIn),
		.extIrqLevel(extIrq), .progEnable(progEn), .progClock(progClk),
		.progData(progDat), .wakeReq(wakeReq));
	board_model board_model_inst (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
		.pullupEn(pullupEn), .pinIn(pinIn), .extEn(extEn), .extVal(extVal));
	// ========================================
	// Reporting and bus tasks
	task automatic complete_run;
		$display("Mismatches %0d, checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check8
	task automatic wbAccess(input logic w, input logic t, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		wbReq <= 1'b1;
		wbWe <= w;
		wbTga <= t;
		wbAdr <= a;
		wbDatI <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1)
		begin
			num_errors++;
			$display("ERROR %0t no bus answer", $time);
			complete_run();
		end
		else
		begin
			q = wbDat[7:0];
			wbReq <= 1'b0;
		end
	endtask : wbAccess
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wbAccess(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		wbAccess(1'b0, 1'b0, a, 8'h00);
		check8(q, exp, "read");
	endtask : rd
	task automatic idle;
		repeat (4) @(posedge clk_sys);
	endtask : idle
	// ========================================
	// Scenarios
	task automatic test_reset;
		rd(`PB_OFF_DIR, 8'hFF); // all inputs
		rd(`PB_OFF_CTRL2, 8'hFF); // pull-ups off
		rd(`PB_OFF_CTRL1, 8'h00); // flag clear
		rd(`PB_OFF_CTRL3, 8'hC0); // reset value
		rd(8'h40, 8'h00); // unmapped reads zero
		check8(pinOe, 8'h00, "oe"); // drivers released
		check8(pullupEn, 8'h00, "pu"); // no pull-ups
	endtask : test_reset
	task automatic test_drive;
		extEn <= 8'h0F;
		extVal <= 8'h06;
		wr(`PB_OFF_LATCH, 8'hA5);
		wr(`PB_OFF_DIR, 8'h0F);
		idle();
		check8(pinOe, 8'hF0, "oe"); // low pins released
		check8(pinOut & 8'hF0, 8'hA0, "out"); // latch driven
		check8({4'h0, extIrq}, 8'h06, "irq"); // synced low pins
		rd(`PB_OFF_PORT, 8'hA6); // pin levels
		rd(`PB_OFF_LATCH, 8'hA5); // latch not pins
		wr(`PB_OFF_PORT, 8'h3C);
		rd(`PB_OFF_LATCH, 8'h3C); // write loads latch
	endtask : test_drive
	task automatic test_pullup;
		extEn <= 8'h00;
		wr(`PB_OFF_CTRL2, 8'h7F);
		idle();
		check8(pullupEn, 8'h0F, "pu"); // outputs stay off
		rd(`PB_OFF_PORT, 8'h3F); // low pins pulled up
		wr(`PB_OFF_CTRL2, 8'hFF);
		extEn <= 8'hFF;
		idle();
		check8(pullupEn, 8'h00, "pu"); // control bit set
	endtask : test_pullup
	task automatic test_change;
		extVal <= 8'h00;
		wr(`PB_OFF_DIR, 8'hFF); // interrupt pins as inputs
		idle();
		rd(`PB_OFF_PORT, 8'h00); // reference taken
		wr(`PB_OFF_CTRL1, 8'h08);
		extVal <= 8'h0F;
		idle();
		rd(`PB_OFF_CTRL1, 8'h08); // low pins ignored
		extVal <= 8'h4F;
		idle(); // wait without polling
		rd(`PB_OFF_CTRL1, 8'h09); // flag set
		check8({7'h0, wakeReq}, 8'h01, "wake"); // wake raised
		wr(`PB_OFF_CTRL1, 8'h08);
		rd(`PB_OFF_CTRL1, 8'h09); // flag stays set
		wbAccess(1'b0, 1'b1, `PB_OFF_PORT, 8'h00);
		wr(`PB_OFF_CTRL1, 8'h08);
		rd(`PB_OFF_CTRL1, 8'h09); // move access ignored
		rd(`PB_OFF_PORT, 8'h4F); // read ends mismatch
		wr(`PB_OFF_CTRL1, 8'h08);
		rd(`PB_OFF_CTRL1, 8'h08); // flag now clears
		check8({7'h0, wakeReq}, 8'h00, "wake"); // wake dropped
		wr(`PB_OFF_DIR, 8'h7F);
		wr(`PB_OFF_LATCH, 8'hBC);
		idle();
		rd(`PB_OFF_CTRL1, 8'h08); // output pin excluded
	endtask : test_change
	task automatic test_config;
		wr(`PB_OFF_DIR, 8'hFF);
		wr(`PB_OFF_CFG, 8'h0A);
		wr(`PB_OFF_CTRL2, 8'h7F);
		extVal <= 8'hE8;
		idle();
		check8({5'h0, progDat, progClk, progEn}, 8'h07, "prog"); // programming pins
		check8(pullupEn, 8'hDF, "pu"); // pin 5 pull-up off
		check8(schmittSel & 8'hE0, 8'hE0, "st"); // Schmitt buffers
		rd(`PB_OFF_PORT, 8'hC8); // pin 5 not I/O
		wr(`PB_OFF_CFG, 8'h05);
		wr(`PB_OFF_LATCH, 8'h00);
		idle();
		check8({7'h0, ccpIn}, 8'h01, "ccp"); // capture routed
		check8(pinOut & 8'h08, 8'h08, "route"); // pin 3 from capture
		check8(schmittSel & 8'h0F, 8'h08, "st"); // capture input Schmitt
		ccpOut <= 1'b0;
		idle();
		check8(pinOut & 8'h08, 8'h00, "route"); // follows capture output
	endtask : test_config
	task automatic test_rereset;
		wr(`PB_OFF_DIR, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(`PB_OFF_DIR, 8'hFF); // inputs after any reset
		rd(`PB_OFF_CTRL2, 8'hFF); // pull-ups off again
		check8(pinOe, 8'h00, "oe"); // drivers released
	endtask : test_rereset
	initial
	begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		test_reset();
		test_drive();
		test_pullup();
		test_change();
		test_config();
		test_rereset();
		complete_run();
	end
endmodule : tb_top
